// ### logic/clock_tree_pkg.sv
// shared constants of the converter clock tree block
package clock_tree_pkg;
  // ****************
  // register offsets
  // ****************
  localparam logic [7:0] CLOCK_CFG_ADDR = 8'h00;
  localparam logic [7:0] LANE_CFG_ADDR = 8'h04;
  localparam logic [7:0] CORE_CFG_ADDR = 8'h08;
  localparam logic [7:0] STATUS_ADDR = 8'h0C;
  localparam logic [7:0] LATENCY_ADDR = 8'h10;
  // ****************
  // field positions
  // ****************
  localparam int IN_BYP_BIT = 0;
  localparam int IN_RATIO_LSB = 1;
  localparam int PHASE_LSB = 3;
  localparam int BIAS_ONE_BIT = 6;
  localparam int BIAS_TWO_BIT = 7;
  localparam int LANE_BYP_BIT = 0;
  localparam int LANE_SEL_LSB = 1;
  localparam int LANE_CNT_LSB = 4;
  localparam int INTERP_LSB = 6;
  localparam int XMODE_LSB = 8;
  localparam int CH_A_BIT = 0;
  localparam int CH_B_BIT = 1;
  localparam int PHCOR_BIT = 2;
  localparam int OSC_BIT = 3;
  localparam int ISINC_BIT = 4;
  localparam int MDLY_LSB = 8;
  localparam int MON_CLR_BIT = 4;
  localparam int PTR_CLR_BIT = 5;
  // ****************
  // reset values
  // ****************
  localparam logic [7:0] CLOCK_CFG_RST = 8'h01;
  // two lanes at x2 with a 1/2 lane divider: both ring sides tick together from reset
  localparam logic [9:0] LANE_CFG_RST = 10'h050;
  localparam logic [16:0] CORE_CFG_RST = 17'h00003;
  localparam logic [3:0] PTR_NOMINAL = 4'hB;
  // ****************
  // sizes and timing
  // ****************
  localparam int DEPTH = 12;
  localparam int SAMPLE_W = 16;
  localparam logic [3:0] LAST_ENTRY = 4'hB;
  localparam logic [1:0] HOLD_TICKS = 2'h2;
  localparam logic [11:0] PHCOR_LAT = 12'h010;
  localparam logic [11:0] OSC_LAT = 12'h010;
  localparam logic [11:0] ISINC_LAT = 12'h004;
  localparam logic [3:0] SKEW_LANE_CLOCKS = 4'h7;
endpackage

// ### logic/clock_tree.sv
// converter clock tree, lane-to-processing domain crossing ring and latency report
`timescale 1ns/100ps
module clock_tree (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // lane side sample
  input wire logic [15:0] lane_sample,
  // derived ticks and data
  output logic converter_tick,
  output logic processing_tick,
  output logic lane_tick,
  output logic output_hold,
  output logic [15:0] processed_sample,
  // channel power
  output logic channel_a_power_on,
  output logic channel_b_power_on
);
  // ****************
  // register file
  // ****************
  logic [7:0] clk_cfg_q, clk_cfg_d;
  logic [9:0] lane_cfg_q, lane_cfg_d;
  logic [16:0] core_cfg_q, core_cfg_d;
  logic mon_flag_q, mon_flag_d;
  logic ptr_flag_q, ptr_flag_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic access, wr_en, mapped;
  logic regen_evt, ptr_evt;
  logic [11:0] latency;
  logic [11:0] base_lat;
  logic [2:0] exp_sel;
  logic exp_byp;
  logic [2:0] div_sum;
  logic [3:0] position;
  logic divided;
  logic hold_q;

  // fields
  logic in_byp, bias1, bias2, lane_byp;
  logic [1:0] in_ratio, lane_cnt, interp, xmode;
  logic [2:0] phase, lane_sel;
  assign in_byp = clk_cfg_q[clock_tree_pkg::IN_BYP_BIT];
  assign in_ratio = clk_cfg_q[clock_tree_pkg::IN_RATIO_LSB +: 2];
  assign phase = clk_cfg_q[clock_tree_pkg::PHASE_LSB +: 3];
  assign bias1 = clk_cfg_q[clock_tree_pkg::BIAS_ONE_BIT];
  assign bias2 = clk_cfg_q[clock_tree_pkg::BIAS_TWO_BIT];
  assign lane_byp = lane_cfg_q[clock_tree_pkg::LANE_BYP_BIT];
  assign lane_sel = lane_cfg_q[clock_tree_pkg::LANE_SEL_LSB +: 3];
  assign lane_cnt = lane_cfg_q[clock_tree_pkg::LANE_CNT_LSB +: 2];
  assign interp = lane_cfg_q[clock_tree_pkg::INTERP_LSB +: 2];
  assign xmode = lane_cfg_q[clock_tree_pkg::XMODE_LSB +: 2];
  // divided mode needs both bias controls on and bypass cleared
  assign divided = bias1 & bias2 & ~in_byp;

  // one wait state so read data leaves a flop
  assign access = psel & penable & ~pready_q;
  assign wr_en = access & pwrite;

  // expected lane divider exponent: lanes + interpolation - 1
  always_comb begin
    div_sum = {1'b0, lane_cnt} + {1'b0, interp};
    exp_byp = (div_sum <= 3'h1);
    exp_sel = exp_byp ? 3'h0 : {2'(div_sum - 3'h2), 1'b0};
  end

  // baseline average latency, x1 shares the x2 figure
  always_comb begin
    base_lat = 12'h0FE;
    case (lane_cnt)
      2'h0: base_lat = (interp == 2'h3) ? 12'h1FC : (interp == 2'h2) ? 12'h13A : 12'h0C7;
      2'h1: base_lat = (interp == 2'h3) ? 12'h250 : (interp == 2'h2) ? 12'h164 : 12'h0DC;
      default: base_lat = (interp == 2'h3) ? 12'h2E8 : (interp == 2'h2) ? 12'h1A8 : 12'h0FE;
    endcase
  end

  // figures hold for aligned lanes and no sync; skew is reported apart
  always_comb begin
    latency = base_lat + core_cfg_q[clock_tree_pkg::MDLY_LSB +: 9];
    if (core_cfg_q[clock_tree_pkg::PHCOR_BIT]) begin
      latency = latency + clock_tree_pkg::PHCOR_LAT;
    end
    if (core_cfg_q[clock_tree_pkg::OSC_BIT]) begin
      latency = latency + clock_tree_pkg::OSC_LAT;
    end
    if (core_cfg_q[clock_tree_pkg::ISINC_BIT]) begin
      latency = latency + clock_tree_pkg::ISINC_LAT;
    end
  end

  always_comb begin
    clk_cfg_d = clk_cfg_q;
    lane_cfg_d = lane_cfg_q;
    core_cfg_d = core_cfg_q;
    mon_flag_d = mon_flag_q;
    ptr_flag_d = ptr_flag_q;
    prdata_d = prdata_q;
    pready_d = access;
    pslverr_d = 1'b0;
    mapped = (paddr == clock_tree_pkg::CLOCK_CFG_ADDR) || (paddr == clock_tree_pkg::LANE_CFG_ADDR) ||
             (paddr == clock_tree_pkg::CORE_CFG_ADDR) || (paddr == clock_tree_pkg::STATUS_ADDR) ||
             (paddr == clock_tree_pkg::LATENCY_ADDR);
    if (access) begin
      pslverr_d = ~mapped | (pwrite & (paddr == clock_tree_pkg::LATENCY_ADDR));
      prdata_d = 32'h0;
      if (!pwrite) begin
        case (paddr)
          clock_tree_pkg::CLOCK_CFG_ADDR: prdata_d = {24'h0, clk_cfg_q};
          clock_tree_pkg::LANE_CFG_ADDR: prdata_d = {22'h0, lane_cfg_q};
          clock_tree_pkg::CORE_CFG_ADDR: prdata_d = {15'h0, core_cfg_q};
          clock_tree_pkg::STATUS_ADDR: prdata_d = {16'h0, clock_tree_pkg::SKEW_LANE_CLOCKS, exp_byp, exp_sel,
                                                   divided, hold_q, ptr_flag_q, mon_flag_q, position};
          clock_tree_pkg::LATENCY_ADDR: prdata_d = {20'h0, latency};
          default: prdata_d = 32'h0;
        endcase
      end
    end
    if (wr_en) begin
      case (paddr)
        clock_tree_pkg::CLOCK_CFG_ADDR: clk_cfg_d = pwdata[7:0];
        clock_tree_pkg::LANE_CFG_ADDR: lane_cfg_d = pwdata[9:0];
        clock_tree_pkg::CORE_CFG_ADDR: core_cfg_d = pwdata[16:0];
        clock_tree_pkg::STATUS_ADDR: begin
          if (pwdata[clock_tree_pkg::MON_CLR_BIT]) begin
            mon_flag_d = 1'b0;
          end
          if (pwdata[clock_tree_pkg::PTR_CLR_BIT]) begin
            ptr_flag_d = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // set beats a clear in the same cycle
    if (regen_evt) begin
      mon_flag_d = 1'b1;
    end
    if (ptr_evt) begin
      ptr_flag_d = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      clk_cfg_q <= clock_tree_pkg::CLOCK_CFG_RST;
      lane_cfg_q <= clock_tree_pkg::LANE_CFG_RST;
      core_cfg_q <= clock_tree_pkg::CORE_CFG_RST;
      mon_flag_q <= 1'b0;
      ptr_flag_q <= 1'b0;
      prdata_q <= 32'h0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else if (ce) begin
      clk_cfg_q <= clk_cfg_d;
      lane_cfg_q <= lane_cfg_d;
      core_cfg_q <= core_cfg_d;
      mon_flag_q <= mon_flag_d;
      ptr_flag_q <= ptr_flag_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ****************
  // clock dividers
  // ****************
  logic [2:0] in_cnt_q, in_cnt_d;
  logic [2:0] in_last, shift;
  logic [2:0] old_phase_q, old_phase_d;
  logic [1:0] hold_cnt_q, hold_cnt_d;
  logic hold_d;
  logic conv_q, conv_d;
  logic [2:0] proc_cnt_q, proc_cnt_d;
  logic [2:0] proc_last;
  logic proc_q, proc_d;
  logic [3:0] lane_cnt_q, lane_cnt_d;
  logic [3:0] lane_last;
  logic lane_q, lane_d;
  logic [3:0] gen_cfg_q;
  logic raw_tick, core_on;

  assign core_on = core_cfg_q[clock_tree_pkg::CH_A_BIT] | core_cfg_q[clock_tree_pkg::CH_B_BIT];
  // changing power or interpolation regenerates the processing tick
  assign regen_evt = (gen_cfg_q != {interp, core_cfg_q[1:0]});

  always_comb begin
    in_last = {in_ratio, 1'b1};
    // half-period phase steps fold onto whole mclk cycles here
    shift = {1'b0, phase[2:1]} % ({1'b0, in_ratio} + 3'h1);
    in_cnt_d = (in_cnt_q >= in_last) ? 3'h0 : in_cnt_q + 3'h1;
    raw_tick = divided ? (in_cnt_q == shift) : 1'b1;
    old_phase_d = phase;
    hold_d = hold_q;
    hold_cnt_d = hold_cnt_q;
    if (divided && (phase != old_phase_q)) begin
      hold_d = 1'b1;
      hold_cnt_d = clock_tree_pkg::HOLD_TICKS;
    end else if (hold_q && raw_tick) begin
      hold_cnt_d = hold_cnt_q - 2'h1;
      hold_d = (hold_cnt_q != 2'h1);
    end
    // suppressing ticks keeps the output at its last value
    conv_d = raw_tick & ~hold_d;
    proc_last = 3'h7 >> (2'h3 - interp);
    proc_cnt_d = proc_cnt_q;
    proc_d = 1'b0;
    lane_last = lane_byp ? 4'h0 : (4'hF >> (2'h3 - lane_sel[2:1]));
    lane_cnt_d = lane_cnt_q;
    lane_d = 1'b0;
    if (conv_d) begin
      proc_cnt_d = (proc_cnt_q >= proc_last) ? 3'h0 : proc_cnt_q + 3'h1;
      proc_d = core_on & (proc_cnt_q == 3'h0);
      lane_cnt_d = (lane_cnt_q >= lane_last) ? 4'h0 : lane_cnt_q + 4'h1;
      lane_d = (lane_cnt_q == 4'h0);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      in_cnt_q <= 3'h0;
      old_phase_q <= 3'h0;
      hold_q <= 1'b0;
      hold_cnt_q <= 2'h0;
      conv_q <= 1'b0;
      proc_cnt_q <= 3'h0;
      proc_q <= 1'b0;
      lane_cnt_q <= 4'h0;
      lane_q <= 1'b0;
      // matches the reset config, so leaving reset is no regeneration
      gen_cfg_q <= {clock_tree_pkg::LANE_CFG_RST[clock_tree_pkg::INTERP_LSB +: 2], clock_tree_pkg::CORE_CFG_RST[1:0]};
    end else if (ce) begin
      in_cnt_q <= in_cnt_d;
      old_phase_q <= old_phase_d;
      hold_q <= hold_d;
      hold_cnt_q <= hold_cnt_d;
      conv_q <= conv_d;
      proc_cnt_q <= proc_cnt_d;
      proc_q <= proc_d;
      lane_cnt_q <= lane_cnt_d;
      lane_q <= lane_d;
      gen_cfg_q <= {interp, core_cfg_q[1:0]};
    end
  end

  // ****************
  // crossing ring
  // ****************
  logic [15:0] ring_q [clock_tree_pkg::DEPTH];
  logic [3:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
  logic [3:0] pos_q;
  logic [15:0] sample_q, sample_d;

  genvar gi;
  generate
    for (gi = 0; gi < clock_tree_pkg::DEPTH; gi++) begin : g_entry
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          ring_q[gi] <= 16'h0;
        end else if (ce && lane_d && (wr_ptr_q == 4'(gi))) begin
          ring_q[gi] <= lane_sample;
        end
      end
    end
  endgenerate

  always_comb begin
    wr_ptr_d = wr_ptr_q;
    rd_ptr_d = rd_ptr_q;
    sample_d = sample_q;
    if (lane_d) begin
      wr_ptr_d = (wr_ptr_q == clock_tree_pkg::LAST_ENTRY) ? 4'h0 : wr_ptr_q + 4'h1;
    end
    if (proc_d) begin
      sample_d = ring_q[rd_ptr_q];
      rd_ptr_d = (rd_ptr_q == clock_tree_pkg::LAST_ENTRY) ? 4'h0 : rd_ptr_q + 4'h1;
    end
    // distance write minus read, modulo twelve
    position = (wr_ptr_q >= rd_ptr_q) ? (wr_ptr_q - rd_ptr_q) : (wr_ptr_q + 4'hC - rd_ptr_q);
  end

  assign ptr_evt = (position != pos_q);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_ptr_q <= clock_tree_pkg::PTR_NOMINAL;
      rd_ptr_q <= 4'h0;
      pos_q <= clock_tree_pkg::PTR_NOMINAL;
      sample_q <= 16'h0;
    end else if (ce) begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      pos_q <= position;
      sample_q <= sample_d;
    end
  end

  // ****************
  // outputs
  // ****************
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign converter_tick = conv_q;
  assign processing_tick = proc_q;
  assign lane_tick = lane_q;
  assign output_hold = hold_q;
  assign processed_sample = sample_q;
  assign channel_a_power_on = core_cfg_q[clock_tree_pkg::CH_A_BIT];
  assign channel_b_power_on = core_cfg_q[clock_tree_pkg::CH_B_BIT];
  // xmode is stored for software only; matching it is the host's duty
  logic unused_xmode;
  assign unused_xmode = ^xmode;
endmodule // clock_tree

// ### testbench/clock_tree_sva.sv
// port-level assertion checker for the clock tree block
`timescale 1ns/100ps
module clock_tree_sva (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // sample and ticks
  input wire logic [15:0] lane_sample,
  input wire logic converter_tick,
  input wire logic processing_tick,
  input wire logic lane_tick,
  input wire logic output_hold,
  input wire logic [15:0] processed_sample,
  // channel power
  input wire logic channel_a_power_on,
  input wire logic channel_b_power_on
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  apb_answer_a: assert property (psel && penable && !pready && ce |=> pready) else $error("apb answer missing");
  ready_pulse_a: assert property (pready && ce |=> !pready) else $error("pready longer than one cycle");
  error_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  latency_ro_a: assert property (pready && pwrite && paddr == clock_tree_pkg::LATENCY_ADDR |-> pslverr)
    else $error("latency write not refused");
  refuse_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0) else $error("refused read not zero");
  sample_hold_a: assert property (!processing_tick |-> $stable(processed_sample))
    else $error("sample moved without processing tick");
  power_gate_a: assert property (!channel_a_power_on && !channel_b_power_on &&
    $past(!channel_a_power_on && !channel_b_power_on, 2) |-> !processing_tick) else $error("tick with cores off");
  freeze_ce_a: assert property (!ce |=> $stable({converter_tick, processing_tick, lane_tick, output_hold, pready}))
    else $error("outputs moved with enable low");
  cover property (pready && pslverr);
  cover property (output_hold);
  cover property (processing_tick && lane_tick);
  cover property (!ce);
endmodule // clock_tree_sva
bind clock_tree clock_tree_sva chk (.mclk(mclk), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .lane_sample(lane_sample),
  .converter_tick(converter_tick), .processing_tick(processing_tick), .lane_tick(lane_tick),
  .output_hold(output_hold), .processed_sample(processed_sample), .channel_a_power_on(channel_a_power_on),
  .channel_b_power_on(channel_b_power_on));

// ### testbench/lane_source.sv
// lane-side sample source standing in for the link receiver
`timescale 1ns/100ps
module lane_source (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // lane timing
  input wire logic lane_tick,
  // sample to the ring
  output logic [15:0] lane_sample
);
  bit seen [65536];
  logic [15:0] v;
  initial seen[0] = 1'b1;
  // fresh value every lane tick, each marked in seen, so a sample that was never sent shows up
  always @(posedge mclk) begin
    if (rst) begin
      lane_sample <= 16'h0000;
    end else if (lane_tick) begin
      v = 16'($urandom);
      seen[v] = 1'b1;
      lane_sample <= v;
    end
  end
endmodule // lane_source

// ### testbench/clock_tree_tb.sv
// self-checking bench for the clock tree block
`timescale 1ns/100ps
module clock_tree_tb;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, converter_tick, processing_tick, lane_tick, output_hold;
  logic channel_a_power_on, channel_b_power_on;
  logic [15:0] lane_sample, processed_sample;
  int n_fail = 0;
  int total_checks = 0;
  int nc, np, nl, nh;
  int lat_t [3][3] = '{'{199, 314, 508}, '{220, 356, 592}, '{254, 424, 744}};
  always #20 mclk = ~mclk;
  clock_tree dut (.mclk(mclk), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .lane_sample(lane_sample),
    .converter_tick(converter_tick), .processing_tick(processing_tick), .lane_tick(lane_tick),
    .output_hold(output_hold), .processed_sample(processed_sample), .channel_a_power_on(channel_a_power_on),
    .channel_b_power_on(channel_b_power_on));
  lane_source src (.mclk(mclk), .rst(rst), .lane_tick(lane_tick), .lane_sample(lane_sample));
  // ****************
  // tasks
  // ****************
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) n_fail++;
  endtask
  // counts windows that are whole multiples of every period under test
  task cnt(input int cyc);
    nc = 0;
    np = 0;
    nl = 0;
    nh = 0;
    repeat (cyc) begin
      @(negedge mclk);
      nc += converter_tick;
      np += processing_tick;
      nl += lane_tick;
      nh += output_hold;
    end
  endtask
  task complete_run;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #(40 * 20000);
    n_fail++;
    complete_run();
  end
  // ****************
  // tests
  // ****************
  initial begin
    int d;
    void'($urandom(94));
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    apb(1'b0, clock_tree_pkg::CLOCK_CFG_ADDR, 32'h0);
    chk(rd, 32'(clock_tree_pkg::CLOCK_CFG_RST));
    apb(1'b0, clock_tree_pkg::LANE_CFG_ADDR, 32'h0);
    chk(rd, 32'(clock_tree_pkg::LANE_CFG_RST));
    apb(1'b0, clock_tree_pkg::CORE_CFG_ADDR, 32'h0);
    chk(rd, 32'(clock_tree_pkg::CORE_CFG_RST));
    apb(1'b0, clock_tree_pkg::STATUS_ADDR, 32'h0);
    chk(rd & 32'hF, 32'hB);
    chk({channel_a_power_on, channel_b_power_on}, 32'h3);
    $display("reset values done");
    for (int s = 0; s < 5; s++) begin
      apb(1'b1, clock_tree_pkg::LANE_CFG_ADDR, (s == 4) ? 32'h61 : 32'h60 | (s << 2));
      repeat (8) @(posedge mclk);
      cnt(32);
      chk(nl, (s == 4) ? 32 : 32 / (2 << s));
      chk(np, 16);
    end
    $display("lane divider done");
    for (int lc = 0; lc < 3; lc++) begin
      for (int ip = 1; ip < 4; ip++) begin
        apb(1'b1, clock_tree_pkg::LANE_CFG_ADDR, (lc << 4) | (ip << 6) | ((ip - 1) << 8) | 1);
        apb(1'b0, clock_tree_pkg::LATENCY_ADDR, 32'h0);
        chk(rd, lat_t[lc][ip - 1]);
        apb(1'b0, clock_tree_pkg::STATUS_ADDR, 32'h0);
        chk(rd[5], 1'b1);
        if (lc + ip == 1) chk(rd[11], 1'b1);
        else chk(rd[11:8], 2 * (lc + ip - 2));
      end
    end
    d = $urandom_range(256, 0);
    apb(1'b1, clock_tree_pkg::LANE_CFG_ADDR, 32'h65);
    apb(1'b1, clock_tree_pkg::CORE_CFG_ADDR, 32'h1F | (d << 8));
    apb(1'b0, clock_tree_pkg::LATENCY_ADDR, 32'h0);
    chk(rd, 254 + d + 36);
    apb(1'b1, clock_tree_pkg::LATENCY_ADDR, 32'h5);
    chk(er, 1'b1);
    apb(1'b0, 8'h20, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    $display("latency done");
    apb(1'b1, clock_tree_pkg::CORE_CFG_ADDR, 32'h0);
    repeat (4) @(posedge mclk);
    chk({channel_a_power_on, channel_b_power_on}, 32'h0);
    cnt(32);
    chk(np, 0);
    apb(1'b1, clock_tree_pkg::CORE_CFG_ADDR, 32'h1);
    repeat (4) @(posedge mclk);
    chk({channel_a_power_on, channel_b_power_on}, 32'h2);
    apb(1'b1, clock_tree_pkg::CORE_CFG_ADDR, 32'h3);
    $display("channel power done");
    for (int ip = 0; ip < 4; ip++) begin
      apb(1'b1, clock_tree_pkg::LANE_CFG_ADDR, 32'h21 | (ip << 6));
      repeat (8) @(posedge mclk);
      cnt(64);
      chk(np, 64 >> ip);
      apb(1'b0, clock_tree_pkg::STATUS_ADDR, 32'h0);
      chk(rd[4], 1'b1);
      apb(1'b1, clock_tree_pkg::STATUS_ADDR, 32'h10);
      apb(1'b0, clock_tree_pkg::STATUS_ADDR, 32'h0);
      chk(rd[4], 1'b0);
    end
    $display("processing clock done");
    for (int r = 0; r < 4; r++) begin
      // ratio only changes during initialization, so each ratio starts from a fresh reset
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      apb(1'b1, clock_tree_pkg::CLOCK_CFG_ADDR, 32'hC0 | (r << 1));
      repeat (10) @(posedge mclk);
      cnt(48);
      chk(nc, 48 / (2 * r + 2));
      apb(1'b1, clock_tree_pkg::CLOCK_CFG_ADDR, 32'hD8 | (r << 1));
      cnt(16);
      chk(nh >= 2, 1'b1);
      apb(1'b0, clock_tree_pkg::STATUS_ADDR, 32'h0);
      chk(rd[7], 1'b1);
    end
    apb(1'b1, clock_tree_pkg::CLOCK_CFG_ADDR, 32'h01);
    $display("input divider done");
    apb(1'b1, clock_tree_pkg::LANE_CFG_ADDR, 32'h21);
    @(posedge mclk);
    ce <= 1'b0;
    repeat (5) @(posedge mclk);
    ce <= 1'b1;
    repeat (20) begin
      @(negedge mclk);
      chk(src.seen[processed_sample], 1'b1);
    end
    apb(1'b0, clock_tree_pkg::STATUS_ADDR, 32'h0);
    chk(rd[3:0] inside {4'hA, 4'hB, 4'h0}, 1'b1);
    chk(rd[5], 1'b0);
    $display("domain crossing done");
    complete_run();
  end
endmodule // clock_tree_tb
